// ==== common/abe_pkg.sv ====
package abe_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Register map, byte addresses on the APB
  localparam logic [7:0] ABE_OFS_INSTR = 8'h00;
  localparam logic [7:0] ABE_OFS_ACC = 8'h04;
  localparam logic [7:0] ABE_OFS_STATUS = 8'h08;
  localparam logic [7:0] ABE_OFS_MEM_PTR = 8'h0C;
  localparam logic [7:0] ABE_OFS_MEM_DATA = 8'h10;

  // Status register fields
  localparam int ABE_ST_CARRY = 0;
  localparam int ABE_ST_NIBBLE = 1;
  localparam int ABE_ST_NULL = 2;
  localparam int ABE_ST_SKIP = 3;

  // Reset values
  localparam logic [7:0] ABE_ACC_RST = 8'h00;
  localparam logic [13:0] ABE_INSTR_RST = 14'h0000;
  localparam logic [6:0] ABE_PTR_RST = 7'h00;

  // Opcode fields
  localparam int ABE_DEST_BIT = 7;
  localparam int ABE_BPOS_LSB = 7;
  localparam int ABE_BSEL_LSB = 10;
  localparam int ABE_MEM_WORDS = 128;

  ////////////////////////////////////////////////////////////////////////////
  typedef enum {
    OP_NONE,
    OP_ADD_IMMEDIATE,
    OP_ADD_WITH_REGISTER,
    OP_AND_IMMEDIATE,
    OP_AND_WITH_REGISTER,
    OP_CLEAR_ONE_BIT,
    OP_SET_ONE_BIT,
    OP_SKIP_WHEN_ZERO,
    OP_SKIP_WHEN_ONE
  } abe_op_type;

  function automatic abe_op_type abe_decode(input logic [13:0] op);
    abe_op_type r;
    r = OP_NONE;
    if (op[13:9] == 5'h1F)
      r = OP_ADD_IMMEDIATE;
    else if (op[13:8] == 6'h39)
      r = OP_AND_IMMEDIATE;
    else if (op[13:8] == 6'h07)
      r = OP_ADD_WITH_REGISTER;
    else if (op[13:8] == 6'h05)
      r = OP_AND_WITH_REGISTER;
    else if (op[13:12] == 2'h1)
    begin
      case (op[11:10])
        2'h0: r = OP_CLEAR_ONE_BIT;
        2'h1: r = OP_SET_ONE_BIT;
        2'h2: r = OP_SKIP_WHEN_ZERO;
        default: r = OP_SKIP_WHEN_ONE;
      endcase
    end
    return r;
  endfunction : abe_decode

endpackage : abe_pkg

// ==== common/abe_alu_if.sv ====
interface abe_alu_if;
  logic [13:0] opcode;
  logic [7:0] acc;
  logic [7:0] fdata;
  logic [7:0] result;
  logic wr_acc;
  logic wr_reg;
  logic upd_arith;
  logic upd_null;
  logic carry;
  logic nibble;
  logic is_null;
  logic skip_next;

  modport core (output opcode, acc, fdata,
                input result, wr_acc, wr_reg, upd_arith, upd_null, carry, nibble, is_null, skip_next);
  modport alu (input opcode, acc, fdata,
               output result, wr_acc, wr_reg, upd_arith, upd_null, carry, nibble, is_null, skip_next);
endinterface : abe_alu_if

// ==== src/abe_alu.sv ====
module abe_alu (
  abe_alu_if.alu a
);
  import abe_pkg::*;

  abe_op_type op;
  logic [7:0] opnd;
  logic [8:0] sum;
  logic [4:0] nib;
  logic [7:0] mask;
  logic tbit;

  always_comb
  begin
    op = abe_decode(a.opcode);
    opnd = (op == OP_ADD_IMMEDIATE || op == OP_AND_IMMEDIATE) ? a.opcode[7:0] : a.fdata;
    sum = {1'b0, a.acc} + {1'b0, opnd};
    nib = {1'b0, a.acc[3:0]} + {1'b0, opnd[3:0]};
    mask = 8'h01 << a.opcode[ABE_BPOS_LSB +: 3];
    tbit = |(a.fdata & mask);
    a.result = 8'h00;
    a.wr_acc = 1'b0;
    a.wr_reg = 1'b0;
    a.upd_arith = 1'b0;
    a.upd_null = 1'b0;
    a.skip_next = 1'b0;
    case (op)
      OP_ADD_IMMEDIATE:
      begin
        a.result = sum[7:0];
        a.wr_acc = 1'b1;
        a.upd_arith = 1'b1;
        a.upd_null = 1'b1;
      end
      OP_ADD_WITH_REGISTER:
      begin
        a.result = sum[7:0];
        a.wr_acc = ~a.opcode[ABE_DEST_BIT];
        a.wr_reg = a.opcode[ABE_DEST_BIT];
        a.upd_arith = 1'b1;
        a.upd_null = 1'b1;
      end
      OP_AND_IMMEDIATE:
      begin
        a.result = a.acc & opnd;
        a.wr_acc = 1'b1;
        a.upd_null = 1'b1;
      end
      OP_AND_WITH_REGISTER:
      begin
        a.result = a.acc & opnd;
        a.wr_acc = ~a.opcode[ABE_DEST_BIT];
        a.wr_reg = a.opcode[ABE_DEST_BIT];
        a.upd_null = 1'b1;
      end
      OP_CLEAR_ONE_BIT:
      begin
        a.result = a.fdata & ~mask;
        a.wr_reg = 1'b1;
      end
      OP_SET_ONE_BIT:
      begin
        a.result = a.fdata | mask;
        a.wr_reg = 1'b1;
      end
      OP_SKIP_WHEN_ZERO: a.skip_next = ~tbit;
      OP_SKIP_WHEN_ONE: a.skip_next = tbit;
      default: a.result = 8'h00;
    endcase
    // Carry out of bit 7 and bit 3 of the addition
    a.carry = sum[8];
    a.nibble = nib[4];
    a.is_null = (a.result == 8'h00);
  end

endmodule : abe_alu

// ==== src/abe_core.sv ====
// The address map and the APB register port were left to the implementer.
module abe_core (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr
);
  import abe_pkg::*;

  abe_alu_if alu_bus ();

  logic [7:0] mem [ABE_MEM_WORDS];
  logic [7:0] acc_reg;
  logic [13:0] instr_reg;
  logic [6:0] ptr_reg;
  logic carry_reg;
  logic nibble_reg;
  logic null_reg;
  logic skip_reg;
  logic [31:0] prdata_next;
  logic slverr_next;
  logic setup;
  logic access_wr;
  logic exec;
  logic [6:0] faddr;
  logic [7:0] fval;

  ////////////////////////////////////////////////////////////////////////////
  // APB slave: zero wait states, read data captured in the setup cycle
  assign pready = 1'b1;
  assign setup = psel & ~penable;
  assign access_wr = psel & penable & pwrite;
  assign exec = access_wr & (paddr == ABE_OFS_INSTR);
  assign faddr = pwdata[6:0];
  assign fval = mem[faddr];

  always_comb
  begin
    prdata_next = 32'h0000_0000;
    slverr_next = 1'b0;
    case (paddr)
      ABE_OFS_INSTR: prdata_next[13:0] = instr_reg;
      ABE_OFS_ACC: prdata_next[7:0] = acc_reg;
      ABE_OFS_STATUS: prdata_next[3:0] = {skip_reg, null_reg, nibble_reg, carry_reg};
      ABE_OFS_MEM_PTR: prdata_next[6:0] = ptr_reg;
      ABE_OFS_MEM_DATA: prdata_next[7:0] = mem[ptr_reg];
      default: slverr_next = 1'b1;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end
    else if (setup)
    begin
      prdata <= pwrite ? 32'h0000_0000 : prdata_next;
      pslverr <= slverr_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Execute path
  assign alu_bus.opcode = pwdata[13:0];
  assign alu_bus.acc = acc_reg;
  assign alu_bus.fdata = fval;

  abe_alu u_alu (
    .a(alu_bus)
  );

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      instr_reg <= ABE_INSTR_RST;
    else if (exec)
      instr_reg <= pwdata[13:0];
  end

  // A pending skip turns the next instruction into a no-op, the second cycle of the test
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      skip_reg <= 1'b0;
    else if (exec)
      skip_reg <= ~skip_reg & alu_bus.skip_next;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      acc_reg <= ABE_ACC_RST;
    else if (exec && !skip_reg && alu_bus.wr_acc)
      acc_reg <= alu_bus.result;
    else if (access_wr && paddr == ABE_OFS_ACC)
      acc_reg <= pwdata[7:0];
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      carry_reg <= 1'b0;
      nibble_reg <= 1'b0;
      null_reg <= 1'b0;
    end
    else if (exec && !skip_reg)
    begin
      if (alu_bus.upd_arith)
      begin
        carry_reg <= alu_bus.carry;
        nibble_reg <= alu_bus.nibble;
      end
      if (alu_bus.upd_null)
        null_reg <= alu_bus.is_null;
    end
    else if (access_wr && paddr == ABE_OFS_STATUS)
    begin
      carry_reg <= pwdata[ABE_ST_CARRY];
      nibble_reg <= pwdata[ABE_ST_NIBBLE];
      null_reg <= pwdata[ABE_ST_NULL];
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      ptr_reg <= ABE_PTR_RST;
    else if (access_wr && paddr == ABE_OFS_MEM_PTR)
      ptr_reg <= pwdata[6:0];
  end

  // Data memory is not reset: contents are undefined until written
  always_ff @(posedge pclk)
  begin
    if (exec && !skip_reg && alu_bus.wr_reg)
      mem[faddr] <= alu_bus.result;
    else if (access_wr && paddr == ABE_OFS_MEM_DATA)
      mem[ptr_reg] <= pwdata[7:0];
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  abe_op_type op_chk;
  logic [4:0] nib_chk;
  logic nib_carry_chk;
  logic [7:0] bmask_chk;
  logic tbit_chk;
  logic [7:0] and_chk;

  assign op_chk = abe_decode(pwdata[13:0]);
  assign nib_chk = {1'b0, acc_reg[3:0]} + {1'b0, pwdata[3:0]};
  assign nib_carry_chk = nib_chk[4];
  assign bmask_chk = 8'h01 << pwdata[9:7];
  assign tbit_chk = |(fval & bmask_chk);
  assign and_chk = acc_reg & fval;

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  chk_add_imm_sum: assert property (exec && !skip_reg && op_chk == OP_ADD_IMMEDIATE |=>
    acc_reg == ($past(acc_reg) + $past(pwdata[7:0])) && null_reg == (acc_reg == 8'h00))
    else $error("add immediate result or zero flag wrong");
  chk_add_reg_sum: assert property (exec && !skip_reg && op_chk == OP_ADD_WITH_REGISTER && !pwdata[7] |=>
    acc_reg == ($past(acc_reg) + $past(fval)))
    else $error("add register result wrong");
  chk_dest_to_reg: assert property (exec && !skip_reg && op_chk == OP_AND_WITH_REGISTER && pwdata[7] |=>
    $stable(acc_reg) && mem[$past(faddr)] == $past(and_chk))
    else $error("register destination not honoured");
  chk_and_imm_flags: assert property (exec && !skip_reg && op_chk == OP_AND_IMMEDIATE |=>
    acc_reg == ($past(acc_reg) & $past(pwdata[7:0])) && $stable(carry_reg) && $stable(nibble_reg))
    else $error("and immediate wrong or arithmetic flags moved");
  chk_and_reg_flags: assert property (exec && !skip_reg && op_chk == OP_AND_WITH_REGISTER |=>
    $stable(carry_reg) && $stable(nibble_reg) && null_reg == ($past(and_chk) == 8'h00))
    else $error("and register flags wrong");
  chk_bit_clear: assert property (exec && !skip_reg && op_chk == OP_CLEAR_ONE_BIT |=>
    mem[$past(faddr)] == ($past(fval) & ~$past(bmask_chk)) && $stable(null_reg) && $stable(carry_reg))
    else $error("bit clear wrong");
  chk_bit_set: assert property (exec && !skip_reg && op_chk == OP_SET_ONE_BIT |=>
    mem[$past(faddr)] == ($past(fval) | $past(bmask_chk)) && $stable(nibble_reg))
    else $error("bit set wrong");
  chk_skip_zero_test: assert property (exec && !skip_reg && op_chk == OP_SKIP_WHEN_ZERO |=>
    skip_reg == !$past(tbit_chk) && $stable(acc_reg))
    else $error("skip when zero decision wrong");
  chk_skip_one_test: assert property (exec && !skip_reg && op_chk == OP_SKIP_WHEN_ONE |=>
    skip_reg == $past(tbit_chk) && $stable(null_reg))
    else $error("skip when one decision wrong");
  chk_skipped_is_nop: assert property (exec && skip_reg |=>
    !skip_reg && $stable(acc_reg) && $stable(carry_reg) && $stable(null_reg))
    else $error("discarded instruction had an effect");
  chk_bitop_decode: assert property (exec && pwdata[13:12] == 2'h1 |->
    op_chk == (pwdata[11] ? (pwdata[10] ? OP_SKIP_WHEN_ONE : OP_SKIP_WHEN_ZERO)
                          : (pwdata[10] ? OP_SET_ONE_BIT : OP_CLEAR_ONE_BIT)))
    else $error("bit operation not decoded");
  chk_nibble_carry: assert property (exec && !skip_reg && op_chk == OP_ADD_IMMEDIATE |=>
    nibble_reg == $past(nib_carry_chk))
    else $error("nibble carry wrong");

  cov_add_carry: cover property (exec && op_chk == OP_ADD_IMMEDIATE ##1 carry_reg);
  cov_skip_taken: cover property (exec && op_chk == OP_SKIP_WHEN_ZERO ##1 skip_reg ##[1:8] exec);
  cov_bit_set: cover property (exec && !skip_reg && op_chk == OP_SET_ONE_BIT);
  cov_and_to_reg: cover property (exec && !skip_reg && op_chk == OP_AND_WITH_REGISTER && pwdata[7]);

endmodule : abe_core

// ==== testbench/abe_core_tb.sv ====
module abe_core_tb;
  timeunit 1ns;
  timeprecision 1ns;
  import abe_pkg::*;

  logic pclk;
  logic presetn;
  logic psel;
  logic penable;
  logic pwrite;
  logic [7:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [31:0] rdata;
  logic rerr;
  int fails;
  int cmp_count;
  logic [15:0] addv [6] = '{16'h0F01, 16'hFF01, 16'h8080, 16'h0000, 16'h1234, 16'h08F8};
  logic [15:0] andv [3] = '{16'hF00F, 16'hF0FF, 16'hAA55};

  abe_core i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));

  ////////////////////////////////////////////////////////////////////////////
  task automatic give_verdict;
    if (fails == 0 && cmp_count > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : give_verdict

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      fails++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  // Request held until pready is seen high; data taken at that edge only
  task automatic apb(input logic wr, input logic [7:0] addr, input logic [31:0] data);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= addr;
    pwdata <= data;
    @(posedge pclk);
    penable <= 1'b1;
    do
      @(posedge pclk);
    while (pready !== 1'b1);
    rdata = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic rd_chk(input logic [7:0] addr, input logic [31:0] exp);
    apb(1'b0, addr, 32'h0);
    check(rdata, exp);
  endtask : rd_chk

  task automatic exec(input logic [13:0] op);
    apb(1'b1, ABE_OFS_INSTR, {18'h0, op});
  endtask : exec

  task automatic mem_wr(input logic [6:0] f, input logic [7:0] v);
    apb(1'b1, ABE_OFS_MEM_PTR, {25'h0, f});
    apb(1'b1, ABE_OFS_MEM_DATA, {24'h0, v});
  endtask : mem_wr

  task automatic mem_chk(input logic [6:0] f, input logic [7:0] v);
    apb(1'b1, ABE_OFS_MEM_PTR, {25'h0, f});
    rd_chk(ABE_OFS_MEM_DATA, {24'h0, v});
  endtask : mem_chk

  // Expected flags of an addition: bit0 carry, bit1 nibble carry, bit2 null
  function automatic logic [31:0] add_st(input logic [7:0] x, input logic [7:0] y);
    logic [8:0] s;
    s = {1'b0, x} + {1'b0, y};
    return {29'h0, s[7:0] == 8'h00, ({1'b0, x[3:0]} + {1'b0, y[3:0]}) > 5'h0F, s[8]};
  endfunction : add_st

  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    pclk = 1'b0;
    forever
      #50 pclk = ~pclk;
  end

  // Whole sequence needs some 810 cycles
  initial
  begin
    repeat (20000) @(posedge pclk);
    fails++;
    give_verdict();
  end

  initial
  begin
    logic [7:0] a;
    logic [7:0] k;
    logic [2:0] b;
    logic sk;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    rd_chk(ABE_OFS_ACC, 32'h0);
    rd_chk(ABE_OFS_STATUS, 32'h0);
    rd_chk(ABE_OFS_INSTR, 32'h0);
    rd_chk(ABE_OFS_MEM_PTR, 32'h0);
    // Unmapped places refuse and leave state alone
    apb(1'b1, 8'h14, 32'hFF);
    check({31'h0, rerr}, 32'h1);
    apb(1'b0, 8'h05, 32'h0);
    check({rdata[30:0], rerr}, 32'h1);
    rd_chk(ABE_OFS_ACC, 32'h0);
    // Skip-pending bit is read-only
    apb(1'b1, ABE_OFS_STATUS, 32'hF);
    rd_chk(ABE_OFS_STATUS, 32'h7);
    for (int i = 0; i < 6; i++)
    begin
      {a, k} = addv[i];
      apb(1'b1, ABE_OFS_ACC, {24'h0, a});
      exec({5'h1F, i[0], k});
      rd_chk(ABE_OFS_ACC, {24'h0, a + k});
      rd_chk(ABE_OFS_STATUS, add_st(a, k));
    end
    rd_chk(ABE_OFS_INSTR, {18'h0, 6'h3F, k});
    for (int i = 0; i < 6; i++)
    begin
      {a, k} = addv[i / 2];
      apb(1'b1, ABE_OFS_ACC, {24'h0, a});
      mem_wr(7'h7F, k);
      exec({6'h07, i[0], 7'h7F});
      rd_chk(ABE_OFS_ACC, {24'h0, i[0] ? a : a + k});
      mem_chk(7'h7F, i[0] ? a + k : k);
      rd_chk(ABE_OFS_STATUS, add_st(a, k));
    end
    // Carry flags preset so that a stray update shows
    for (int i = 0; i < 6; i++)
    begin
      {a, k} = (i < 3) ? andv[i] : andv[i / 2];
      apb(1'b1, ABE_OFS_STATUS, 32'h3);
      apb(1'b1, ABE_OFS_ACC, {24'h0, a});
      mem_wr(7'h00, k);
      if (i < 3)
        exec({6'h39, k});
      else
        exec({6'h05, i[0], 7'h00});
      rd_chk(ABE_OFS_ACC, {24'h0, (i > 2 && i[0]) ? a : a & k});
      mem_chk(7'h00, (i > 2 && i[0]) ? a & k : k);
      rd_chk(ABE_OFS_STATUS, {29'h0, (a & k) == 8'h00, 2'h3});
    end
    for (int i = 0; i < 8; i++)
    begin
      b = 3'(i);
      apb(1'b1, ABE_OFS_STATUS, 32'h5);
      mem_wr({b, 4'h3}, 8'hFF);
      exec({4'h4, b, b, 4'h3});
      mem_chk({b, 4'h3}, 8'hFF & ~(8'h01 << b));
      mem_wr({b, 4'h3}, 8'h00);
      exec({4'h5, b, b, 4'h3});
      mem_chk({b, 4'h3}, 8'h01 << b);
      rd_chk(ABE_OFS_STATUS, 32'h5);
    end
    // Other bits hold the opposite level so a wrong bit index shows
    for (int i = 0; i < 4; i++)
    begin
      b = 3'(i * 2 + 1);
      sk = (i < 2) ? !i[0] : i[0];
      apb(1'b1, ABE_OFS_STATUS, 32'h0);
      apb(1'b1, ABE_OFS_ACC, 32'h1);
      mem_wr(7'h10, i[0] ? 8'h01 << b : ~(8'h01 << b));
      exec({2'h1, 1'b1, i[1], b, 7'h10});
      rd_chk(ABE_OFS_STATUS, {28'h0, sk, 3'h0});
      exec({6'h3E, 8'h01});
      rd_chk(ABE_OFS_ACC, sk ? 32'h1 : 32'h2);
      rd_chk(ABE_OFS_STATUS, 32'h0);
    end
    give_verdict();
  end

endmodule : abe_core_tb
